// >>> t1fsc_pkg.sv
// Constants shared by the T1 framer status and error counter block
package t1fsc_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_STATUS_ONE = 8'h20;
  localparam logic [7:0] ADDR_STATUS_TWO = 8'h21;
  localparam logic [7:0] ADDR_CV_HIGH    = 8'h23;
  localparam logic [7:0] ADDR_CV_LOW     = 8'h24;
  localparam logic [7:0] ADDR_MASK_TWO   = 8'h6f;
  localparam logic [7:0] ADDR_CONTROL    = 8'h7b;
  localparam logic [7:0] ADDR_MATCH_ONE  = 8'h7c;
  localparam logic [7:0] ADDR_MATCH_TWO  = 8'h7d;
  localparam logic [7:0] ADDR_MASK_ONE   = 8'h7e;
  localparam logic [7:0] REG_RESET       = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int LOOP_UP_BIT   = 7;
  localparam int LOOP_DOWN_BIT = 6;
  localparam int RX_MFRAME_BIT = 7;
  localparam int TX_MFRAME_BIT = 6;
  localparam int SECOND_BIT    = 5;
  localparam int RFULL_BIT     = 4;
  localparam int TEMPTY_BIT    = 3;
  localparam int MATCH_BIT     = 2;
  localparam int ABORT_BIT     = 1;
  localparam int RCLOST_BIT    = 0;
  localparam int CTL_EXZ_BIT   = 0;
  localparam int CTL_B8ZS_BIT  = 1;

  // ****************************************************************
  // Timing and line figures
  // ****************************************************************
  localparam int CLOCK_MHZ       = 200;
  localparam int LINE_KHZ        = 1544;
  localparam int RCLOST_NS       = 3000;
  localparam int RCLOST_CYCLES   = (RCLOST_NS * CLOCK_MHZ + 999) / 1000;
  localparam int LOOP_WINDOW_MS  = 48;
  localparam int LOOP_WINDOW_BITS = LOOP_WINDOW_MS * LINE_KHZ;
  localparam int SECOND_SHORT_MS = 999;
  localparam int SECOND_LONG_MS  = 1002;
  localparam int SECOND_PHASES   = 3;
  localparam int LOOP_UP_PERIOD  = 5;
  localparam int LOOP_DOWN_PERIOD = 3;
  localparam int LOOP_ERR_SHIFT  = 4;
  localparam int EXZ_PLAIN_RUN   = 16;
  localparam int EXZ_B8ZS_RUN    = 8;
  localparam int ABORT_ONES      = 8;
  localparam int CV_WIDTH        = 16;
endpackage : t1fsc_pkg

// >>> t1fsc_loop_detect.sv
// Loop code detector integrating one repeating pattern over a window
`timescale 1ns/100ps
`default_nettype none
module t1fsc_loop_detect #(
  parameter int PERIOD      = t1fsc_pkg::LOOP_UP_PERIOD,
  parameter int WINDOW_BITS = t1fsc_pkg::LOOP_WINDOW_BITS,
  parameter int ONES_LO_SH  = 3,
  parameter int ONES_HI_SH  = 2
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic bitStrobe,
  input  wire logic bitValue,
  output logic      hit
);
  localparam int CW = $clog2(WINDOW_BITS + 1);
  localparam logic [CW-1:0] LAST    = CW'(WINDOW_BITS - 1);
  localparam logic [CW-1:0] ERR_MAX = CW'(WINDOW_BITS >> t1fsc_pkg::LOOP_ERR_SHIFT);
  localparam logic [CW-1:0] ONES_LO = CW'(WINDOW_BITS >> ONES_LO_SH);
  localparam logic [CW-1:0] ONES_HI = CW'(WINDOW_BITS >> ONES_HI_SH);

  typedef struct packed {
    logic [PERIOD-1:0] hist;
    logic [CW-1:0]     bits;
    logic [CW-1:0]     errs;
    logic [CW-1:0]     ones;
    logic              hit;
  } t1fsc_ld_s;

  t1fsc_ld_s st;
  t1fsc_ld_s next_st;

  // Periodicity and density test; framing bits and line errors only
  // add a few mismatches, so a budget of errors is tolerated
  always_comb begin
    next_st     = st;
    next_st.hit = 1'b0;
    if (bitStrobe) begin
      next_st.hist = {st.hist[PERIOD-2:0], bitValue};
      if (st.bits == LAST) begin
        next_st.hit  = (st.errs < ERR_MAX) && (st.ones > ONES_LO)
                       && (st.ones < ONES_HI);
        next_st.bits = '0;
        next_st.errs = '0;
        next_st.ones = '0;
      end else begin
        next_st.bits = st.bits + CW'(1);
        next_st.errs = st.errs + CW'(bitValue ^ st.hist[PERIOD-1]);
        next_st.ones = st.ones + CW'(bitValue);
      end
    end
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign hit = st.hit;
endmodule : t1fsc_loop_detect
`default_nettype wire

// >>> t1fsc_sec_timer.sv
// One-second timer counting receive clock edges in a 3-second cycle
`timescale 1ns/100ps
`default_nettype none
module t1fsc_sec_timer #(
  parameter int EDGES_PER_MS = t1fsc_pkg::LINE_KHZ
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic lineEdge,
  output logic      secTick
);
  typedef struct packed {
    logic [10:0] edges;
    logic [10:0] msec;
    logic [1:0]  phase;
    logic        tick;
  } t1fsc_sec_s;

  t1fsc_sec_s st;
  t1fsc_sec_s next_st;
  logic [10:0] msLimit;

  // Two short seconds then one long one keep 3 s exact on average
  always_comb begin
    next_st      = st;
    next_st.tick = 1'b0;
    msLimit = (st.phase == 2'(t1fsc_pkg::SECOND_PHASES - 1))
              ? 11'(t1fsc_pkg::SECOND_LONG_MS - 1)
              : 11'(t1fsc_pkg::SECOND_SHORT_MS - 1);
    if (lineEdge) begin
      if (st.edges == 11'(EDGES_PER_MS - 1)) begin
        next_st.edges = '0;
        if (st.msec == msLimit) begin
          next_st.msec  = '0;
          next_st.tick  = 1'b1;
          next_st.phase = (st.phase == 2'(t1fsc_pkg::SECOND_PHASES - 1))
                          ? 2'h0 : st.phase + 2'h1;
        end else begin
          next_st.msec = st.msec + 11'h1;
        end
      end else begin
        next_st.edges = st.edges + 11'h1;
      end
    end
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign secTick = st.tick;
endmodule : t1fsc_sec_timer
`default_nettype wire

// >>> t1fsc_status_counters.sv
// T1 framer status flags, interrupt masks and code violation counter
//
// Summary of operation
// - Loop up and down shown in status one
// - Loop code flag set after 48 ms window
// - Detect codes framed or unframed despite errors
// - Second flag in 999, 999, 1002 ms cycle
// - Flag transmit link buffer empty
// - Flag received link byte matching either byte
// - Flag abort on eight ones in link
// - Flag receive clock lost after 3 us
// - Latch counters at each one-second boundary
// - Counters saturate, never wrap
// - Counter 16 bits, high 0x23, low 0x24
// - Count violations, zero runs, skip B8ZS words
// - Counter runs even without frame sync
`timescale 1ns/100ps
`default_nettype none
module t1fsc_status_counters #(
  parameter int LOOP_WINDOW_BITS = t1fsc_pkg::LOOP_WINDOW_BITS,
  parameter int EDGES_PER_MS     = t1fsc_pkg::LINE_KHZ
) (
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire logic [7:0] address,
  input  wire logic [7:0] writeData,
  input  wire logic       writeStrobe,
  input  wire logic       readStrobe,
  output logic      [7:0] readData,
  output logic            interruptRequest,
  input  wire logic       recvClock,
  input  wire logic       recvPos,
  input  wire logic       recvNeg,
  input  wire logic [5:0] alarmEvents,
  input  wire logic       recvMultiframe,
  input  wire logic       xmitMultiframe,
  input  wire logic       linkBufferFull,
  input  wire logic       xmitLinkEmpty,
  input  wire logic       linkBitStrobe,
  input  wire logic       linkBit,
  input  wire logic       linkByteStrobe,
  input  wire logic [7:0] linkByte
);
  localparam int CW = t1fsc_pkg::CV_WIDTH;
  localparam logic [CW-1:0] CV_MAX = '1;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic          rclkPrev;
    logic [7:0]    statusOne;
    logic [7:0]    statusTwo;
    logic [7:0]    maskOne;
    logic [7:0]    maskTwo;
    logic [7:0]    matchOne;
    logic [7:0]    matchTwo;
    logic [1:0]    control;
    logic [7:0]    readData;
    logic [9:0]    lossCount;
    logic          lastPol;
    logic          oldPol;
    logic [7:0]    symPos;
    logic [7:0]    symNeg;
    logic [7:0]    viol;
    logic [4:0]    zeroRun;
    logic [2:0]    onesRun;
    logic [CW-1:0] accum;
    logic [CW-1:0] cvCount;
  } t1fsc_state_s;

  t1fsc_state_s st;
  t1fsc_state_s next_st;

  // Sticky flag: a set in the clearing cycle wins
  function automatic logic [7:0] sticky(input logic [7:0] old,
                                        input logic [7:0] set,
                                        input logic [7:0] clr);
    sticky = set | (old & ~clr);
  endfunction : sticky

  // Add without passing the top of the counter
  function automatic logic [CW-1:0] satAdd(input logic [CW-1:0] a,
                                           input logic [1:0] inc);
    logic [CW:0] sum;
    sum = {1'b0, a} + (CW+1)'(inc);
    satAdd = sum[CW] ? CV_MAX : sum[CW-1:0];
  endfunction : satAdd

  // ****************************************************************
  // Helpers
  // ****************************************************************
  logic       rclkEdge;
  logic       loopUpHit;
  logic       loopDownHit;
  logic       secTick;
  logic       lineMark;
  logic       violIn;
  logic       wordSeen;
  logic [7:0] violMasked;
  logic       bpvOut;
  logic       exzEvent;
  logic [4:0] exzLimit;
  logic [1:0] cvInc;
  logic [CW-1:0] accumSum;
  logic       lossHit;
  logic       matchHit;
  logic       abortHit;
  logic [7:0] setOne;
  logic [7:0] setTwo;
  logic [7:0] clrOne;
  logic [7:0] clrTwo;

  assign rclkEdge = recvClock & ~st.rclkPrev;
  assign lineMark = recvPos | recvNeg;

  // ****************************************************************
  // Loop code detectors and second timer
  // ****************************************************************
  t1fsc_loop_detect #(
    .PERIOD      (t1fsc_pkg::LOOP_UP_PERIOD),
    .WINDOW_BITS (LOOP_WINDOW_BITS),
    .ONES_LO_SH  (3),
    .ONES_HI_SH  (2)
  ) upDetect (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .bitStrobe (rclkEdge),
    .bitValue  (lineMark),
    .hit       (loopUpHit)
  );

  t1fsc_loop_detect #(
    .PERIOD      (t1fsc_pkg::LOOP_DOWN_PERIOD),
    .WINDOW_BITS (LOOP_WINDOW_BITS),
    .ONES_LO_SH  (2),
    .ONES_HI_SH  (1)
  ) downDetect (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .bitStrobe (rclkEdge),
    .bitValue  (lineMark),
    .hit       (loopDownHit)
  );

  t1fsc_sec_timer #(
    .EDGES_PER_MS (EDGES_PER_MS)
  ) secTimer (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .lineEdge (rclkEdge),
    .secTick  (secTick)
  );

  // ****************************************************************
  // Line code checks
  // ****************************************************************
  // Violations wait eight bits so a whole substitution word can veto
  // its own two intentional violations before they are counted
  always_comb begin
    violIn   = rclkEdge & lineMark & (recvPos == st.lastPol);
    wordSeen = st.control[t1fsc_pkg::CTL_B8ZS_BIT]
      && !(st.symPos[7] | st.symNeg[7]) && !(st.symPos[6] | st.symNeg[6])
      && !(st.symPos[5] | st.symNeg[5]) && !(st.symPos[2] | st.symNeg[2])
      && (st.symPos[4] ^ st.symNeg[4]) && (st.symPos[3] ^ st.symNeg[3])
      && (st.symPos[1] ^ st.symNeg[1]) && (st.symPos[0] ^ st.symNeg[0])
      && (st.symPos[4] == st.oldPol) && (st.symPos[3] != st.symPos[4])
      && (st.symPos[1] == st.symPos[3]) && (st.symPos[0] != st.symPos[1]);
    violMasked = wordSeen ? (st.viol & 8'hed) : st.viol;
    bpvOut     = rclkEdge & violMasked[7];
    exzLimit   = st.control[t1fsc_pkg::CTL_B8ZS_BIT]
                 ? 5'(t1fsc_pkg::EXZ_B8ZS_RUN) : 5'(t1fsc_pkg::EXZ_PLAIN_RUN);
    exzEvent   = rclkEdge & !lineMark & st.control[t1fsc_pkg::CTL_EXZ_BIT]
                 & (st.zeroRun == exzLimit - 5'h1);
    cvInc      = 2'(bpvOut) + 2'(exzEvent);
    accumSum   = satAdd(st.accum, cvInc);
  end

  // ****************************************************************
  // Event sources
  // ****************************************************************
  assign lossHit  = !rclkEdge && (st.lossCount == 10'(t1fsc_pkg::RCLOST_CYCLES - 1));
  assign matchHit = linkByteStrobe && ((linkByte == st.matchOne)
                                    || (linkByte == st.matchTwo));
  assign abortHit = linkBitStrobe && linkBit
                    && (st.onesRun == 3'(t1fsc_pkg::ABORT_ONES - 1));
  assign setOne   = {loopUpHit, loopDownHit, alarmEvents};
  assign setTwo   = {recvMultiframe, xmitMultiframe, secTick, linkBufferFull,
                     xmitLinkEmpty, matchHit, abortHit, lossHit};
  assign clrOne   = (writeStrobe && address == t1fsc_pkg::ADDR_STATUS_ONE)
                    ? writeData : 8'h00;
  assign clrTwo   = (writeStrobe && address == t1fsc_pkg::ADDR_STATUS_TWO)
                    ? writeData : 8'h00;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_st           = st;
    next_st.rclkPrev  = recvClock;
    next_st.statusOne = sticky(st.statusOne, setOne, clrOne);
    next_st.statusTwo = sticky(st.statusTwo, setTwo, clrTwo);
    // Clock watchdog restarts on every edge and holds once expired
    if (rclkEdge) begin
      next_st.lossCount = '0;
    end else if (!lossHit && st.lossCount < 10'(t1fsc_pkg::RCLOST_CYCLES)) begin
      next_st.lossCount = st.lossCount + 10'h1;
    end else begin
      next_st.lossCount = 10'(t1fsc_pkg::RCLOST_CYCLES);
    end
    // Symbol window and run lengths
    if (rclkEdge) begin
      next_st.symPos  = {st.symPos[6:0], recvPos};
      next_st.symNeg  = {st.symNeg[6:0], recvNeg};
      next_st.viol    = {violMasked[6:0], violIn};
      next_st.zeroRun = lineMark ? 5'h0
                        : (st.zeroRun == exzLimit - 5'h1) ? 5'h0 : st.zeroRun + 5'h1;
      if (lineMark) begin
        next_st.lastPol = recvPos;
      end
      if (st.symPos[7] | st.symNeg[7]) begin
        next_st.oldPol = st.symPos[7];
      end
    end else begin
      next_st.viol = violMasked;
    end
    if (linkBitStrobe) begin
      next_st.onesRun = (!linkBit || abortHit) ? 3'h0 : st.onesRun + 3'h1;
    end
    // Counter is never gated by frame sync; it latches each second
    if (secTick) begin
      next_st.cvCount = accumSum;
      next_st.accum   = '0;
    end else begin
      next_st.accum = accumSum;
    end
    // Register writes
    if (writeStrobe) begin
      case (address)
        t1fsc_pkg::ADDR_MASK_ONE:  next_st.maskOne  = writeData;
        t1fsc_pkg::ADDR_MASK_TWO:  next_st.maskTwo  = writeData;
        t1fsc_pkg::ADDR_MATCH_ONE: next_st.matchOne = writeData;
        t1fsc_pkg::ADDR_MATCH_TWO: next_st.matchTwo = writeData;
        t1fsc_pkg::ADDR_CONTROL:   next_st.control  = writeData[1:0];
        default:                   next_st.control  = st.control;
      endcase
    end
    // Register reads; unmapped addresses answer zero
    next_st.readData = 8'h00;
    if (readStrobe) begin
      case (address)
        t1fsc_pkg::ADDR_STATUS_ONE: next_st.readData = st.statusOne;
        t1fsc_pkg::ADDR_STATUS_TWO: next_st.readData = st.statusTwo;
        t1fsc_pkg::ADDR_CV_HIGH:    next_st.readData = st.cvCount[15:8];
        t1fsc_pkg::ADDR_CV_LOW:     next_st.readData = st.cvCount[7:0];
        t1fsc_pkg::ADDR_MASK_ONE:   next_st.readData = st.maskOne;
        t1fsc_pkg::ADDR_MASK_TWO:   next_st.readData = st.maskTwo;
        t1fsc_pkg::ADDR_MATCH_ONE:  next_st.readData = st.matchOne;
        t1fsc_pkg::ADDR_MATCH_TWO:  next_st.readData = st.matchTwo;
        t1fsc_pkg::ADDR_CONTROL:    next_st.readData = {6'h00, st.control};
        default:                    next_st.readData = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st          <= '0;
      st.maskOne  <= t1fsc_pkg::REG_RESET;
      st.maskTwo  <= t1fsc_pkg::REG_RESET;
      st.matchOne <= t1fsc_pkg::REG_RESET;
      st.matchTwo <= t1fsc_pkg::REG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs; interrupt is a level from registered flags and masks
  assign readData         = st.readData;
  assign interruptRequest = |(st.statusOne & st.maskOne)
                            | |(st.statusTwo & st.maskTwo);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence clearTwoSeq;
    writeStrobe && address == t1fsc_pkg::ADDR_STATUS_TWO;
  endsequence

  sequence frameMarkSeq;
    recvMultiframe && writeData[t1fsc_pkg::RX_MFRAME_BIT];
  endsequence

  loop_up_flag_a: assert property (loopUpHit |=> st.statusOne[t1fsc_pkg::LOOP_UP_BIT])
    else $error("loop up detection did not set its flag");
  loop_down_flag_a: assert property (loopDownHit |=> st.statusOne[t1fsc_pkg::LOOP_DOWN_BIT])
    else $error("loop down detection did not set its flag");
  set_wins_a: assert property (clearTwoSeq ##0 frameMarkSeq |=>
                               st.statusTwo[t1fsc_pkg::RX_MFRAME_BIT])
    else $error("multiframe event lost under clear");
  sec_latch_a: assert property (secTick |=> st.cvCount == $past(accumSum)
                                && st.accum == '0)
    else $error("counter not latched at second boundary");
  link_flags_a: assert property (xmitLinkEmpty && matchHit |=>
      st.statusTwo[t1fsc_pkg::TEMPTY_BIT] && st.statusTwo[t1fsc_pkg::MATCH_BIT])
    else $error("link flags not set");
  abort_flag_a: assert property (linkBitStrobe && linkBit && st.onesRun == 3'h7 |=>
                                 st.statusTwo[t1fsc_pkg::ABORT_BIT])
    else $error("abort flag not set on eighth one");
  clock_loss_a: assert property (lossHit |-> !$rose(recvClock) ##1
                                 st.statusTwo[t1fsc_pkg::RCLOST_BIT])
    else $error("receive clock loss flag missing");
  cv_saturate_a: assert property (st.accum == CV_MAX && !secTick |=> st.accum == CV_MAX)
    else $error("violation counter wrapped");
  cv_count_a: assert property (bpvOut && !exzEvent && !secTick && st.accum < CV_MAX
                               |=> st.accum == $past(st.accum) + 16'h1)
    else $error("violation not counted");
  irq_gate_a: assert property ((st.statusTwo & st.maskTwo) != 8'h00 ##1
                               (st.statusTwo & st.maskTwo) != 8'h00
                               |-> interruptRequest)
    else $error("unmasked flag without interrupt");
endmodule : t1fsc_status_counters
`default_nettype wire

// >>> t1fsc_mcu_model.sv
// Microcontroller model that drives the register port of the block
`timescale 1ns/100ps
`default_nettype none
module t1fsc_mcu_model (
  input  wire logic       clock,
  output logic      [7:0] address,
  output logic      [7:0] writeData,
  output logic            writeStrobe,
  output logic            readStrobe,
  input  wire logic [7:0] readData
);
  // Idle bus at time zero
  initial begin
    address     = 8'h00;
    writeData   = 8'h00;
    writeStrobe = 1'b0;
    readStrobe  = 1'b0;
  end

  // One write cycle; the strobe drops at the next edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    address     <= a;
    writeData   <= d;
    writeStrobe <= 1'b1;
    @(posedge clock);
    writeStrobe <= 1'b0;
  endtask : write_reg

  // Data stands only in the cycle after the strobe, so take it then
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    address    <= a;
    readStrobe <= 1'b1;
    @(posedge clock);
    readStrobe <= 1'b0;
    #1 d = readData;
  endtask : read_reg
endmodule : t1fsc_mcu_model
`default_nettype wire

// >>> t1fsc_status_counters_tb.sv
// Self-checking testbench of the status flags, masks and interrupt
`timescale 1ns/100ps
`default_nettype none
module t1fsc_status_counters_tb;
  localparam int WIN = 200;
  logic       clock;
  logic       sys_rst;
  logic [7:0] address;
  logic [7:0] writeData;
  logic       writeStrobe;
  logic       readStrobe;
  logic [7:0] readData;
  logic       interruptRequest;
  logic       recvClock;
  logic       recvPos;
  logic       recvNeg;
  logic [5:0] alarmEvents;
  logic [3:0] ev;
  logic       linkBitStrobe;
  logic       linkBit;
  logic       linkByteStrobe;
  logic [7:0] linkByte;
  logic       pol;
  int         errCount;
  int         compares;

  t1fsc_mcu_model u_mcu (.clock(clock), .address(address), .writeData(writeData),
    .writeStrobe(writeStrobe), .readStrobe(readStrobe), .readData(readData));

  t1fsc_status_counters #(.LOOP_WINDOW_BITS(WIN), .EDGES_PER_MS(1)) DUT (
    .clock(clock), .sys_rst(sys_rst),
    .address(address), .writeData(writeData), .writeStrobe(writeStrobe),
    .readStrobe(readStrobe), .readData(readData), .interruptRequest(interruptRequest),
    .recvClock(recvClock), .recvPos(recvPos), .recvNeg(recvNeg), .alarmEvents(alarmEvents),
    .recvMultiframe(ev[3]), .xmitMultiframe(ev[2]), .linkBufferFull(ev[1]),
    .xmitLinkEmpty(ev[0]), .linkBitStrobe(linkBitStrobe), .linkBit(linkBit),
    .linkByteStrobe(linkByteStrobe), .linkByte(linkByte));

  // 200 MHz clock
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      errCount++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    u_mcu.read_reg(a, d);
    check($sformatf("reg %h", a), exp, d);
  endtask : rdchk

  task automatic irqchk(input logic exp);
    @(posedge clock);
    #1 check("interruptRequest", {7'h00, exp}, {7'h00, interruptRequest});
  endtask : irqchk

  // One-cycle event pulses on the flag inputs
  task automatic pulse(input logic [5:0] al, input logic [3:0] e);
    @(posedge clock);
    alarmEvents <= al;
    ev          <= e;
    @(posedge clock);
    alarmEvents <= 6'h00;
    ev          <= 4'h0;
  endtask : pulse

  // One line bit; marks alternate, the first one negative, so only the first mark after reset makes a bipolar violation
  task automatic line_bit(input logic b);
    @(posedge clock);
    recvClock <= 1'b1;
    recvPos   <= b & pol;
    recvNeg   <= b & ~pol;
    pol       <= pol ^ b;
    @(posedge clock);
    recvClock <= 1'b0;
  endtask : line_bit

  task automatic link_ones(input int n);
    for (int i = 0; i <= n; i++) begin
      @(posedge clock);
      linkBitStrobe <= 1'b1;
      linkBit       <= (i < n);
    end
    @(posedge clock);
    linkBitStrobe <= 1'b0;
  endtask : link_ones

  task automatic link_byte(input logic [7:0] b);
    @(posedge clock);
    linkByteStrobe <= 1'b1;
    linkByte       <= b;
    @(posedge clock);
    linkByteStrobe <= 1'b0;
  endtask : link_byte

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset;
    rdchk(8'h6f, 8'h00);
    rdchk(8'h7e, 8'h00);
    rdchk(8'h23, 8'h00);
    rdchk(8'h24, 8'h00);
    rdchk(8'h30, 8'h00);
    u_mcu.write_reg(8'h6f, 8'ha5);
    u_mcu.write_reg(8'h23, 8'h55);
    rdchk(8'h6f, 8'ha5);
    rdchk(8'h23, 8'h00);
    u_mcu.write_reg(8'h6f, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_clock_loss;
    repeat (700) @(posedge clock);
    rdchk(8'h21, 8'h01);
    u_mcu.write_reg(8'h21, 8'h01);
    rdchk(8'h21, 8'h00);
    $display("test_clock_loss done");
  endtask : test_clock_loss

  task automatic test_flags_irq;
    pulse(6'h3f, 4'hf);
    rdchk(8'h20, 8'h3f);
    rdchk(8'h21, 8'hd8);
    irqchk(1'b0);
    u_mcu.write_reg(8'h6f, 8'h08);
    irqchk(1'b1);
    u_mcu.write_reg(8'h21, 8'h08);
    irqchk(1'b0);
    rdchk(8'h21, 8'hd0);
    // Multiframe event in the very cycle its bit is cleared must survive
    fork
      pulse(6'h00, 4'h8);
      u_mcu.write_reg(8'h21, 8'h80);
    join
    rdchk(8'h21, 8'hd0);
    u_mcu.write_reg(8'h21, 8'hff);
    u_mcu.write_reg(8'h20, 8'hff);
    u_mcu.write_reg(8'h7e, 8'h01);
    irqchk(1'b0);
    pulse(6'h01, 4'h0);
    irqchk(1'b1);
    u_mcu.write_reg(8'h20, 8'h01);
    irqchk(1'b0);
    u_mcu.write_reg(8'h7e, 8'h00);
    $display("test_flags_irq done");
  endtask : test_flags_irq

  task automatic test_link;
    u_mcu.write_reg(8'h7c, 8'h3c);
    u_mcu.write_reg(8'h7d, 8'h5a);
    link_byte(8'h11);
    rdchk(8'h21, 8'h00);
    link_byte(8'h5a);
    rdchk(8'h21, 8'h04);
    u_mcu.write_reg(8'h21, 8'h04);
    link_byte(8'h3c);
    rdchk(8'h21, 8'h04);
    u_mcu.write_reg(8'h21, 8'h04);
    // Match and buffer empty in one cycle both land
    fork
      link_byte(8'h5a);
      pulse(6'h00, 4'h1);
    join
    rdchk(8'h21, 8'h0c);
    u_mcu.write_reg(8'h21, 8'h0c);
    link_ones(7);
    rdchk(8'h21, 8'h00);
    link_ones(8);
    rdchk(8'h21, 8'h02);
    u_mcu.write_reg(8'h21, 8'hff);
    $display("test_link done");
  endtask : test_link

  // Loop codes with one bit error in every fifty, well inside the budget
  task automatic test_loop;
    for (int i = 0; i < 3 * WIN; i++) line_bit((i % 5 == 4) ^ (i % 50 == 7));
    rdchk(8'h20, 8'h80);
    for (int i = 0; i < 2 * WIN; i++) line_bit((i % 3 == 2) ^ (i % 50 == 7));
    u_mcu.write_reg(8'h20, 8'hff);
    for (int i = 0; i < 2 * WIN; i++) line_bit((i % 3 == 2) ^ (i % 50 == 7));
    rdchk(8'h20, 8'h40);
    $display("test_loop done");
  endtask : test_loop

  // Timer runs one edge per ms here, so ticks fall on edges 999 and 1998;
  // the loop test leaves a one-zero run, so zero runs complete on zeros
  // 15, 31 .. 591 of this test: 37 before the tick on edge 1998
  task automatic test_counter;
    u_mcu.write_reg(8'h21, 8'hff);
    u_mcu.write_reg(8'h7b, 8'h01);
    for (int i = 0; i < 600; i++) line_bit(1'b0);
    rdchk(8'h21, 8'h20);
    rdchk(8'h23, 8'h00);
    rdchk(8'h24, 8'h25);
    $display("test_counter done");
  endtask : test_counter

  task automatic complete_run;
    $display("compares %0d mismatches %0d", compares, errCount);
    if (errCount == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : complete_run

  // Main sequence; a short second lets the counter latch be seen
  initial begin
    sys_rst        = 1'b1;
    recvClock      = 1'b0;
    recvPos        = 1'b0;
    recvNeg        = 1'b0;
    alarmEvents    = 6'h00;
    ev             = 4'h0;
    linkBitStrobe  = 1'b0;
    linkBit        = 1'b0;
    linkByteStrobe = 1'b0;
    linkByte       = 8'h00;
    pol            = 1'b0;
    errCount       = 0;
    compares       = 0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    test_reset();
    test_clock_loss();
    test_flags_irq();
    test_link();
    test_loop();
    test_counter();
    complete_run();
  end
endmodule : t1fsc_status_counters_tb
`default_nettype wire
